/* File: core/mft_defines.svh */
// Offsets, field positions and reset values of the fault and TLB control block
`ifndef MFT_DEFINES_SVH
`define MFT_DEFINES_SVH
`define MFT_OFF_FLAGS    8'h00
`define MFT_OFF_ACK      8'h04
`define MFT_OFF_BASE_HI  8'h08
`define MFT_OFF_BASE_LO  8'h0c
`define MFT_OFF_LOCK     8'h10
`define MFT_OFF_FADDR_HI 8'h14
`define MFT_OFF_FADDR_LO 8'h18
`define MFT_OFF_CTRL     8'h1c
`define MFT_OFF_MASK     8'h20
`define MFT_BIT_NOENTRY  0
`define MFT_BIT_NOWALK   1
`define MFT_BIT_PERM     2
`define MFT_BIT_PREF     3
`define MFT_FLAGS_W      4
`define MFT_BIT_ACK      0
`define MFT_BIT_WALKEN   2
`define MFT_BASE_HI_MSB  15
`define MFT_BASE_LO_MSB  15
`define MFT_BASE_LO_LSB  7
`define MFT_BASE_LO_W    9
`define MFT_BASE_W       25
`define MFT_VICT_MSB     8
`define MFT_VICT_LSB     4
`define MFT_LBASE_MSB    14
`define MFT_LBASE_LSB    10
`define MFT_PTR_W        5
`define MFT_VA_W         24
`define MFT_FA_HI_W      8
`define MFT_FA_LO_W      16
`define MFT_ADDR_W       8
`define MFT_RST_FLAGS    4'h0
`define MFT_RST_PTR      5'h00
`define MFT_RST_BASE     25'h0000000
`define MFT_RESP_OKAY    2'h0
`define MFT_RESP_SLVERR  2'h2
`define MFT_PTR_LAST     5'h1f
`endif

/* File: core/mft_pkg.sv */
// Types shared by the fault and TLB control block
package mft_pkg;
    // Fault events reported by the translation datapath in one cycle
    typedef struct packed {
        logic        lookupMiss;
        logic        walkNoEntry;
        logic        permViolation;
        logic        prefetch;
        logic [23:0] vaddr;
    } mft_evt_s;
    // Read channel states
    typedef enum logic [0:0] {
        MFT_RD_IDLE = 1'b0,
        MFT_RD_RESP = 1'b1
    } mft_rd_e;
endpackage

/* File: core/mft_fault_tlb_ctrl.sv */
// Fault reporting, interrupt acknowledge, table base and TLB lock pointers
`timescale 1ns/1ps
`include "mft_defines.svh"

module mft_fault_tlb_ctrl (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // AXI4-Lite write channels
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Translation datapath side
    input  wire mft_pkg::mft_evt_s    faultEvt,
    input  wire logic                 victimAdvance,
    output logic                      walkerEnable,
    output logic [24:0]               tableBase,
    output logic [4:0]                victimPtr,
    output logic [4:0]                lockBase,
    // Fault interrupt
    output logic                      faultIrq
);

    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic        doWrite;
    logic        wrHit;
    logic [31:0] wd;
    logic [3:0]  flags_reg;
    logic [3:0]  flagsSet;
    logic [3:0]  mask_reg;
    logic        ackWrite;
    logic [23:0] faultAddr_reg;
    logic        anyFault;
    logic        cfgOpen;
    logic [4:0]  victimNext;
    logic [31:0] rdValue;
    logic        rdHit;
    mft_pkg::mft_rd_e rdState_reg;

    // Write data with byte strobes applied
    always_comb begin
        wd = s_axi_wdata;
        for (int i = 0; i < 4; i++) begin
            // Lanes left off by the strobe write zeros, not old contents
            wd[i*8 +: 8] = s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8] : 8'h00;
        end
    end

    // Address and data are latched separately, in either order
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_reg    <= wd;
                s_axi_wready <= 1'b0;
            end
            // Reopen both only once the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Both halves held and no response pending
    assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Write decode; mapped offsets answer OKAY even if locked
    always_comb begin
        case (awAddr_reg)
            `MFT_OFF_FLAGS, `MFT_OFF_ACK, `MFT_OFF_BASE_HI, `MFT_OFF_BASE_LO,
            `MFT_OFF_LOCK, `MFT_OFF_FADDR_HI, `MFT_OFF_FADDR_LO,
            `MFT_OFF_CTRL, `MFT_OFF_MASK: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MFT_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `MFT_RESP_OKAY : `MFT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign ackWrite = doWrite && (awAddr_reg == `MFT_OFF_ACK)
                      && wData_reg[`MFT_BIT_ACK];
    // Base and lock words are frozen while the walker runs
    assign cfgOpen = !walkerEnable;

    // Walker enable control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            walkerEnable <= 1'b0;
        end else if (doWrite && awAddr_reg == `MFT_OFF_CTRL) begin
            walkerEnable <= wData_reg[`MFT_BIT_WALKEN];
        end
    end

    // Interrupt mask, same layout as the flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_reg <= `MFT_RST_FLAGS;
        end else if (doWrite && awAddr_reg == `MFT_OFF_MASK) begin
            mask_reg <= wData_reg[`MFT_FLAGS_W-1:0];
        end
    end

    // Fault classification from one event cycle
    always_comb begin
        flagsSet = `MFT_RST_FLAGS;
        flagsSet[`MFT_BIT_NOWALK]  = faultEvt.lookupMiss && !walkerEnable;
        flagsSet[`MFT_BIT_NOENTRY] = faultEvt.walkNoEntry && walkerEnable;
        flagsSet[`MFT_BIT_PERM]    = faultEvt.permViolation;
        // Prefetch fails on either a plain miss or an empty walk
        flagsSet[`MFT_BIT_PREF]    = faultEvt.prefetch
            && (flagsSet[`MFT_BIT_NOWALK] || flagsSet[`MFT_BIT_NOENTRY]);
    end
    assign anyFault = |flagsSet;

    // Sticky flags; a new fault in the acknowledge cycle survives it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_reg <= `MFT_RST_FLAGS;
        end else begin
            flags_reg <= (ackWrite ? `MFT_RST_FLAGS : flags_reg) | flagsSet;
        end
    end

    // Address of the latest fault
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultAddr_reg <= 24'h000000;
        end else if (anyFault) begin
            faultAddr_reg <= faultEvt.vaddr;
        end
    end

    // Level interrupt, registered, from unmasked pending flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultIrq <= 1'b0;
        end else begin
            faultIrq <= |((ackWrite ? `MFT_RST_FLAGS : flags_reg) & mask_reg
                          | (flagsSet & mask_reg));
        end
    end

    // Translation table base, written only with the walker off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tableBase <= `MFT_RST_BASE;
        end else if (doWrite && cfgOpen) begin
            if (awAddr_reg == `MFT_OFF_BASE_HI) begin
                tableBase[`MFT_BASE_W-1:`MFT_BASE_LO_W] <=
                    wData_reg[`MFT_BASE_HI_MSB:0];
            end
            if (awAddr_reg == `MFT_OFF_BASE_LO) begin
                tableBase[`MFT_BASE_LO_W-1:0] <=
                    wData_reg[`MFT_BASE_LO_MSB:`MFT_BASE_LO_LSB];
            end
        end
    end

    // Victim steps past the locked region and wraps back to its base
    always_comb begin
        if (victimPtr == `MFT_PTR_LAST || victimPtr + 5'h01 < lockBase) begin
            victimNext = lockBase;
        end else begin
            victimNext = victimPtr + 5'h01;
        end
    end

    // Lock pointers: host write when the walker is off, walker advance otherwise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            victimPtr <= `MFT_RST_PTR;
            lockBase  <= `MFT_RST_PTR;
        end else if (doWrite && cfgOpen && awAddr_reg == `MFT_OFF_LOCK) begin
            victimPtr <= wData_reg[`MFT_VICT_MSB:`MFT_VICT_LSB];
            lockBase  <= wData_reg[`MFT_LBASE_MSB:`MFT_LBASE_LSB];
        end else if (victimAdvance && walkerEnable) begin
            victimPtr <= victimNext;
        end
    end

    // Read mux; unused bits stay zero
    always_comb begin
        rdValue = 32'h00000000;
        rdHit   = 1'b1;
        case (s_axi_araddr)
            `MFT_OFF_FLAGS:    rdValue[`MFT_FLAGS_W-1:0] = flags_reg;
            `MFT_OFF_ACK:      rdValue = 32'h00000000;
            `MFT_OFF_BASE_HI:
                rdValue[`MFT_BASE_HI_MSB:0] = tableBase[`MFT_BASE_W-1:`MFT_BASE_LO_W];
            `MFT_OFF_BASE_LO:
                rdValue[`MFT_BASE_LO_MSB:`MFT_BASE_LO_LSB] = tableBase[`MFT_BASE_LO_W-1:0];
            `MFT_OFF_LOCK: begin
                rdValue[`MFT_VICT_MSB:`MFT_VICT_LSB]   = victimPtr;
                rdValue[`MFT_LBASE_MSB:`MFT_LBASE_LSB] = lockBase;
            end
            `MFT_OFF_FADDR_HI:
                rdValue[`MFT_FA_HI_W-1:0] = faultAddr_reg[`MFT_VA_W-1:`MFT_FA_LO_W];
            `MFT_OFF_FADDR_LO:
                rdValue[`MFT_FA_LO_W-1:0] = faultAddr_reg[`MFT_FA_LO_W-1:0];
            `MFT_OFF_CTRL:     rdValue[`MFT_BIT_WALKEN] = walkerEnable;
            `MFT_OFF_MASK:     rdValue[`MFT_FLAGS_W-1:0] = mask_reg;
            default:           rdHit = 1'b0;
        endcase
    end

    // Read channel: one beat, answer in the cycle after address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdState_reg   <= mft_pkg::MFT_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `MFT_RESP_OKAY;
        end else begin
            case (rdState_reg)
                mft_pkg::MFT_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= rdValue;
                        s_axi_rresp   <= rdHit ? `MFT_RESP_OKAY : `MFT_RESP_SLVERR;
                        rdState_reg   <= mft_pkg::MFT_RD_RESP;
                    end
                end
                mft_pkg::MFT_RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rdState_reg   <= mft_pkg::MFT_RD_IDLE;
                    end
                end
                default: rdState_reg <= mft_pkg::MFT_RD_IDLE;
            endcase
        end
    end

    // Checks on this block's own registers and outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seqAck;
        ackWrite && (flagsSet == `MFT_RST_FLAGS);
    endsequence
    sequence seqCleared;
        (flags_reg == `MFT_RST_FLAGS) && !faultIrq;
    endsequence

    AST_MISS_NOWALK: assert property (
        faultEvt.lookupMiss && !walkerEnable |=> flags_reg[`MFT_BIT_NOWALK])
        else $error("walker-off miss not flagged");
    AST_WALK_EMPTY: assert property (
        faultEvt.walkNoEntry && walkerEnable |=> flags_reg[`MFT_BIT_NOENTRY])
        else $error("translation fault not flagged");
    AST_PERM: assert property (
        faultEvt.permViolation |=> flags_reg[`MFT_BIT_PERM])
        else $error("permission fault not flagged");
    AST_PREF: assert property (
        faultEvt.prefetch && faultEvt.lookupMiss && !walkerEnable
        |=> flags_reg[`MFT_BIT_PREF])
        else $error("prefetch error not flagged");
    AST_PREF_CAUSE: assert property (
        $rose(flags_reg[`MFT_BIT_PREF]) |-> $past(faultEvt.prefetch))
        else $error("prefetch error without prefetch");
    AST_ACK_CLEARS: assert property (
        seqAck ##1 1'b1 |-> seqCleared)
        else $error("acknowledge did not clear fault state");
    AST_HOLD: assert property (
        flags_reg[`MFT_BIT_PERM] && !ackWrite |=> flags_reg[`MFT_BIT_PERM])
        else $error("flag dropped without acknowledge");
    AST_IRQ: assert property (
        |(flags_reg & mask_reg) && !ackWrite |=> faultIrq)
        else $error("pending unmasked fault without interrupt");
    AST_FADDR: assert property (
        anyFault |=> faultAddr_reg == $past(faultEvt.vaddr))
        else $error("fault address not captured");
    AST_LOCK_FROZEN: assert property (
        walkerEnable && !victimAdvance |=> $stable(lockBase) && $stable(victimPtr))
        else $error("lock word changed while walking");
    AST_VICTIM_FLOOR: assert property (
        victimAdvance && walkerEnable && lockBase <= victimPtr
        |=> victimPtr >= lockBase)
        else $error("victim entered locked region");
    AST_VICTIM_WRAP: assert property (
        victimAdvance && walkerEnable && victimPtr == `MFT_PTR_LAST
        |=> victimPtr == lockBase)
        else $error("victim did not wrap to lock base");

endmodule

/* File: tb/mft_dp_model.sv */
// Translation datapath stand-in: fault events and victim replacement pulses
`timescale 1ns/1ps

module mft_dp_model (
    // Clock
    input  wire logic          clk,
    // Toward the block
    output mft_pkg::mft_evt_s  faultEvt,
    output logic               victimAdvance
);
    // Quiet until commanded
    initial begin
        faultEvt      = '0;
        victimAdvance = 1'h0;
    end

    // One-cycle event; prefetch only rides on a miss or an empty walk
    task automatic fire(input logic [3:0] k, input logic [23:0] va);
        @(posedge clk);
        faultEvt <= {k, va};
        @(posedge clk);
        faultEvt <= {4'h0, ~va}; // Stale address must not look valid
    endtask

    // Walker replaced the current victim entry
    task automatic advance();
        @(posedge clk);
        victimAdvance <= 1'h1;
        @(posedge clk);
        victimAdvance <= 1'h0;
    endtask
endmodule

/* File: tb/mft_fault_tlb_ctrl_tb_top.sv */
// Self-checking bench for the fault and TLB control block
`timescale 1ns/1ps

module mft_fault_tlb_ctrl_tb_top;
    logic              clk = 1'h0;
    logic              sys_rst = 1'h1;
    logic [7:0]        awaddr = 8'h00;
    logic [7:0]        araddr = 8'h00;
    logic [31:0]       wdata = 32'h0;
    logic [3:0]        wstrb = 4'hf;
    logic              awvalid = 1'h0;
    logic              wvalid = 1'h0;
    logic              bready = 1'h0;
    logic              arvalid = 1'h0;
    logic              rready = 1'h0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              walkerEnable, faultIrq, victimAdvance;
    logic [24:0]       tableBase;
    logic [4:0]        victimPtr, lockBase;
    mft_pkg::mft_evt_s faultEvt;
    logic [33:0]       expQ[$];
    int                numErrors = 0;
    int                nTests = 0;
    int                seed = 22;
    logic [31:0]       d;
    logic [3:0]        f;
    logic [3:0]        kinds[5] = '{4'h8, 4'h4, 4'h2, 4'h9, 4'h5};
    logic [7:0]        offs[6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h20};
    logic [4:0]        vexp[3] = '{5'h1f, 5'h03, 5'h04};

    mft_fault_tlb_ctrl uut (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .faultEvt(faultEvt), .victimAdvance(victimAdvance),
        .walkerEnable(walkerEnable), .tableBase(tableBase),
        .victimPtr(victimPtr), .lockBase(lockBase), .faultIrq(faultIrq)
    );

    mft_dp_model dp (
        .clk(clk), .faultEvt(faultEvt), .victimAdvance(victimAdvance)
    );

    // Free-running 10 MHz clock
    always #50 clk = ~clk;

    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic hang();
        numErrors++;
        $display("bus answer never came");
        summarize();
    endtask

    // Bus answers are matched against the oldest pending note
    always @(posedge clk) begin
        if (bvalid && bready)
            chk("bresp", {bresp, 32'h0}, expQ.pop_front());
        if (rvalid && rready)
            chk("rdata", {rresp, rdata}, expQ.pop_front());
    end

    // Write: address and data together, bready held until the response
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        int n;
        @(posedge clk);
        expQ.push_back({r, 32'h0});
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        if (n == 40) hang();
    endtask

    // Read: rready held until rvalid is sampled
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        @(posedge clk);
        expQ.push_back(e);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        if (n == 40) hang();
    endtask

    // Flag pattern a fault event should leave, worked out from its cause
    function automatic logic [3:0] flagsFor(input logic w, input logic [3:0] k);
        logic [3:0] r;
        r[1] = k[3] & ~w;
        r[0] = k[2] & w;
        r[2] = k[1];
        r[3] = k[0] & (r[0] | r[1]);
        return r;
    endfunction

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        foreach (offs[i]) rd(offs[i], 34'h0);
        rd(8'h04, 34'h0);
        rd(8'h24, {2'h2, 32'h0});
        wr(8'h28, 32'hffffffff, 2'h2);
        $display("test reset_and_unmapped done");
        d = $random(seed);
        wr(8'h08, d, 2'h0);
        rd(8'h08, {18'h0, d[15:0]});
        wr(8'h0c, ~d, 2'h0);
        rd(8'h0c, {18'h0, ~d[15:7], 7'h00});
        @(negedge clk);
        chk("tableBase", tableBase, {d[15:0], ~d[15:7]});
        d = $random(seed);
        d[14:10] = 5'h03;
        d[8:4] = 5'h1e;
        wr(8'h10, d, 2'h0);
        rd(8'h10, 34'h0de0);
        chk("lockBase", lockBase, 5'h03);
        chk("victimPtr", victimPtr, 5'h1e);
        $display("test base_and_lock done");
        // Masked fault: flag set, interrupt held off
        dp.fire(4'h2, 24'h5a5a5a);
        repeat (2) @(negedge clk);
        chk("faultIrqMasked", faultIrq, 1'h0);
        rd(8'h00, 34'h4);
        wr(8'h04, 32'h1, 2'h0);
        wr(8'h20, 32'hffffffff, 2'h0);
        rd(8'h20, 34'hf);
        $display("test masked_fault done");
        for (int w = 0; w < 2; w++) begin
            wr(8'h1c, {29'h0, w[0], 2'h0}, 2'h0);
            @(negedge clk);
            chk("walkerEnable", walkerEnable, w[0]);
            foreach (kinds[i]) begin
                d = $random(seed);
                f = flagsFor(w[0], kinds[i]);
                dp.fire(kinds[i], d[23:0]);
                repeat (2) @(negedge clk);
                chk("faultIrq", faultIrq, |f);
                rd(8'h00, {30'h0, f});
                if (f != 4'h0) begin
                    rd(8'h14, {26'h0, d[23:16]});
                    rd(8'h18, {18'h0, d[15:0]});
                end
                wr(8'h04, 32'hfffffffe, 2'h0);
                rd(8'h00, {30'h0, f});
                wr(8'h04, 32'h1, 2'h0);
                rd(8'h00, 34'h0);
                @(negedge clk);
                chk("faultIrqAck", faultIrq, 1'h0);
            end
            $display("test fault_causes done");
        end
        // Walker on: lock word is frozen, victim walks and skips locked entries
        wr(8'h10, 32'h0, 2'h0);
        rd(8'h10, 34'h0de0);
        foreach (vexp[i]) begin
            dp.advance();
            @(negedge clk);
            chk("victimPtr", victimPtr, vexp[i]);
        end
        $display("test victim_walk done");
        summarize();
    end
endmodule
